// File: bench/rlsr_host.sv
`timescale 1ns/1ps
// Host on the control interface: single bytes, one-cycle strobes.
module rlsr_host (
   input wire clk,
   output logic [7:0] reg_addr,
   output logic reg_wr,
   output logic reg_rd,
   output logic [7:0] reg_wdata
);
   initial begin
      reg_addr = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_wdata = 8'h00;
   end
   // Released lines show the inverse, so stale values cannot pass a check.
   task automatic access(input logic w, input logic [7:0] a, d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= w;
      reg_rd <= !w;
      @(posedge clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      reg_addr <= ~a;
      reg_wdata <= ~d;
   endtask
endmodule

// File: bench/rlsr_regs_props.sv
`timescale 1ns/1ps
// Timing relations of the register slice, seen only at its ports.
module rlsr_regs_props (
   input wire clk,
   input wire reset,
   input wire [7:0] reg_addr,
   input wire reg_wr,
   input wire reg_rd,
   input wire [7:0] reg_wdata,
   input wire reg_rvalid_r,
   input wire [4:0] limit_resistor_pin,
   input wire limit_override_sel,
   input wire [3:0] active_ramp_code_r,
   input wire [13:0] ramp_time_us_r,
   input wire [4:0] active_limit_code_r,
   input wire [10:0] limit_threshold_mv_r,
   input wire overcurrent_warning_flag_r,
   input wire alert_r,
   input wire lock_state_r
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   // Scaled outputs lag their codes by one edge, so reset edges are skipped.
   a_read_answer: assert property (reg_rd |=> reg_rvalid_r)
      else $error("read strobe not answered next cycle");
   a_answer_cause: assert property (reg_rvalid_r |-> $past(reg_rd))
      else $error("read answer without a read strobe");
   a_alert_flag: assert property (alert_r == overcurrent_warning_flag_r)
      else $error("alert differs from overcurrent flag");
   a_lock_sticky: assert property (lock_state_r |=> lock_state_r)
      else $error("lock released without power cycle");
   a_lock_set: assert property (reg_wr && reg_addr == 8'h2A
      && reg_wdata[0] |=> lock_state_r)
      else $error("lock write did not set lock");
   a_limit_follow: assert property (!limit_override_sel
      |=> active_limit_code_r == $past(limit_resistor_pin))
      else $error("limit code does not follow resistor");
   a_limit_scale: assert property (!$past(reset) |->
      limit_threshold_mv_r == 11'h0C8 + 11'h032 *
      {6'h00, $past(active_limit_code_r)})
      else $error("limit threshold scaling wrong");
   a_ramp_scale: assert property (!$past(reset) |->
      ramp_time_us_r == (($past(active_ramp_code_r) < 4'h6) ?
      14'h0096 * ({10'h000, $past(active_ramp_code_r)} + 14'h0001) :
      ($past(active_ramp_code_r) == 4'h6) ? 14'h03E8 :
      14'h03E8 * {10'h000, $past(active_ramp_code_r) - 4'h5}))
      else $error("ramp time scaling wrong");
endmodule
bind rlsr_regs rlsr_regs_props u_props (.clk, .reset, .reg_addr, .reg_wr,
   .reg_rd, .reg_wdata, .reg_rvalid_r, .limit_resistor_pin,
   .limit_override_sel, .active_ramp_code_r, .ramp_time_us_r,
   .active_limit_code_r, .limit_threshold_mv_r,
   .overcurrent_warning_flag_r, .alert_r, .lock_state_r);

// File: bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   logic clk = 1'b0;
   logic reset = 1'b1;
   wire [7:0] reg_addr, reg_wdata, reg_rdata_r;
   wire reg_wr, reg_rd, reg_rvalid_r, alert_r, lock_state_r;
   wire [3:0] active_ramp_code_r;
   wire [13:0] ramp_time_us_r;
   wire [4:0] active_limit_code_r;
   wire [10:0] limit_threshold_mv_r;
   wire overcurrent_warning_flag_r;
   logic [7:0] current_sense_pin = 8'h00, phase_limit_hit = 8'h00;
   logic current_sense_valid = 1'b0, ramp_override_sel = 1'b0;
   logic [3:0] ramp_select_pin = 4'h0;
   logic [4:0] limit_resistor_pin = 5'h00;
   logic limit_override_sel = 1'b0;
   int miscompares = 0;
   int n_checks = 0;
   int e;
   logic [7:0] exp_q[$];
   logic [7:0] rnd = 8'h09, sense;
   always #5 clk = ~clk;
   rlsr_host host (.clk, .reg_addr, .reg_wr, .reg_rd, .reg_wdata);
   rlsr_regs dut (.clk, .reset, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
      .reg_rdata_r, .reg_rvalid_r, .current_sense_pin, .current_sense_valid,
      .ramp_select_pin, .ramp_override_sel, .limit_resistor_pin,
      .limit_override_sel, .phase_limit_hit, .active_ramp_code_r,
      .ramp_time_us_r, .active_limit_code_r, .limit_threshold_mv_r,
      .overcurrent_warning_flag_r, .alert_r, .lock_state_r);
   function automatic [7:0] lfsr(input [7:0] s);
      lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   task automatic chk(input logic [15:0] got, exp);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, d);
      host.access(1'b1, a, d);
   endtask
   // The expected byte is noted before the strobe; the monitor pops it.
   task automatic rd(input logic [7:0] a, ex);
      exp_q.push_back(ex);
      host.access(1'b0, a, 8'h00);
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic done(input string s);
      $display("test %s done", s);
   endtask
   task automatic end_sim;
      // An expected read that never got its answer is a mismatch too.
      if (exp_q.size() != 0)
         miscompares++;
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // Read answers are sampled at the edge that ends their single cycle.
   always @(posedge clk) begin
      if (reg_rvalid_r === 1'b1 && exp_q.size() != 0)
         chk({8'h00, reg_rdata_r}, {8'h00, exp_q.pop_front()});
   end
   initial begin
      #100000;
      miscompares++;
      end_sim;
   end
   initial begin
      @(posedge clk);
      ramp_select_pin <= rnd[3:0];
      sense = lfsr(rnd) | 8'h80;
      repeat (11) @(posedge clk);
      reset <= 1'b0;
      rd(8'h2B, {4'h0, ramp_select_pin});
      rd(8'h20, 8'hFF);
      rd(8'h24, 8'h00);
      rd(8'h7F, 8'h00);
      // Strap code 9 with no override selects 4 ms.
      chk({2'b00, ramp_time_us_r}, 16'h0FA0);
      done("power_on");
      current_sense_pin <= sense;
      current_sense_valid <= 1'b1;
      @(posedge clk);
      current_sense_valid <= 1'b0;
      wr(8'h20, 8'h7F);
      settle(3);
      chk({15'h0000, overcurrent_warning_flag_r}, 16'h0001);
      chk({15'h0000, alert_r}, 16'h0001);
      rd(8'h26, sense);
      rd(8'h24, 8'h01);
      wr(8'h20, sense);
      settle(3);
      chk({15'h0000, overcurrent_warning_flag_r}, 16'h0000);
      chk({15'h0000, alert_r}, 16'h0000);
      rd(8'h24, 8'h00);
      done("warning");
      ramp_override_sel <= 1'b1;
      for (int c = 0; c < 16; c++) begin
         wr(8'h2C, {4'hF, 4'(c)});
         settle(4);
         e = (c < 6) ? 150 * (c + 1) : (c == 6) ? 1000 : (c - 5) * 1000;
         chk({2'b00, ramp_time_us_r}, e[15:0]);
      end
      rd(8'h2C, 8'h0F);
      done("ramp");
      for (int i = 0; i < 2; i++) begin
         rnd = lfsr(rnd);
         limit_resistor_pin <= rnd[4:0];
         settle(3);
         e = 200 + 50 * rnd[4:0];
         chk({11'h000, active_limit_code_r}, {11'h000, rnd[4:0]});
         chk({5'h00, limit_threshold_mv_r}, e[15:0]);
      end
      wr(8'h2E, 8'hFF);
      limit_override_sel <= 1'b1;
      settle(4);
      chk({5'h00, limit_threshold_mv_r}, 16'h06D6);
      rd(8'h2E, 8'h1F);
      done("limit");
      phase_limit_hit <= 8'h81;
      rd(8'h2D, 8'h81);
      rd(8'h2D, 8'h00);
      done("phase");
      wr(8'h2A, 8'hFF);
      rd(8'h2A, 8'h01);
      wr(8'h2E, 8'h05);
      wr(8'h20, 8'h00);
      wr(8'h2C, 8'h03);
      wr(8'h2A, 8'h00);
      rd(8'h2E, 8'h1F);
      rd(8'h20, sense);
      rd(8'h2C, 8'h0F);
      rd(8'h2A, 8'h01);
      @(posedge clk);
      reset <= 1'b1;
      repeat (12) @(posedge clk);
      reset <= 1'b0;
      rd(8'h2A, 8'h00);
      rd(8'h20, 8'hFF);
      settle(3);
      done("lock");
      end_sim;
   end
endmodule

// File: rtl/rlsr_defs.vh
`ifndef RLSR_DEFS_VH
`define RLSR_DEFS_VH

// Register offsets on the control interface.
`define RLSR_ADDR_WARN_LIMIT 8'h20
`define RLSR_ADDR_WARN_STATUS 8'h24
`define RLSR_ADDR_READBACK 8'h26
`define RLSR_ADDR_LOCK 8'h2A
`define RLSR_ADDR_RAMP_STATUS 8'h2B
`define RLSR_ADDR_RAMP_CONFIG 8'h2C
`define RLSR_ADDR_PHASE_STATUS 8'h2D
`define RLSR_ADDR_PHASE_CONFIG 8'h2E

// Field positions.
`define RLSR_WARN_BIT 0
`define RLSR_LOCK_BIT 0
`define RLSR_RAMP_MSB 3
`define RLSR_LIMIT_MSB 4

// Reset values.
`define RLSR_WARN_LIMIT_RST 8'hFF
`define RLSR_RAMP_CONFIG_RST 4'h0
`define RLSR_RAMP_STATUS_RST 4'h0
`define RLSR_PHASE_CONFIG_RST 5'h00
`define RLSR_READBACK_RST 8'h00

// Ramp time table, in microseconds at a 1 V reference.
`define RLSR_RAMP_FAST_STEP_US 14'd150
`define RLSR_RAMP_CODE6_US 14'd1000
`define RLSR_RAMP_SLOW_STEP_US 14'd1000
`define RLSR_RAMP_FIRST_SLOW 4'h7
`define RLSR_RAMP_SLOW_OFFSET 4'h5
`define RLSR_RAMP_CODE6 4'h6

// Phase limit threshold, in millivolts.
`define RLSR_LIMIT_BASE_MV 11'd200
`define RLSR_LIMIT_STEP_MV 11'd50

`endif

// File: rtl/rlsr_regs.v
`timescale 1ns/1ps
`include "rlsr_defs.vh"

// Operation
// - Warning status bit 0 is set while readback exceeds the warning limit.
// - Readback register returns the 8-bit conversion; full code means 2 V.
// - Writing one to lock bit 0 freezes every lockable limit register.
// - Lock holds until power cycles; no register write can clear it.
// - At power-on the ramp strap code is loaded into ramp status.
// - Ramp config holds a 4-bit host code that can override the strap.
// - Written ramp code applies only when its select bit is set.
// - Ramp code in bits 3:0 maps to 0.15 ms up to 10 ms.
// - By default the phase limit follows the resistor-derived code continuously.
// - Phase limit config holds a 5-bit code in bits 4:0.
// - Programmed limit code replaces resistor code only when selected.
// - Limit code maps 0x00 to 0.2 V, steps 50 mV, to 1.75 V.
// - A phase entering current limit sets its status bit.
// - Status bit 0 is phase 1 up to bit 7 for phase 8.
// - Exceeding the warning limit also raises the overcurrent flag and alert.
// - Warning limit register resets to all ones.
module rlsr_regs (
   clk,
   reset,
   reg_addr,
   reg_wr,
   reg_rd,
   reg_wdata,
   reg_rdata_r,
   reg_rvalid_r,
   current_sense_pin,
   current_sense_valid,
   ramp_select_pin,
   ramp_override_sel,
   limit_resistor_pin,
   limit_override_sel,
   phase_limit_hit,
   active_ramp_code_r,
   ramp_time_us_r,
   active_limit_code_r,
   limit_threshold_mv_r,
   overcurrent_warning_flag_r,
   alert_r,
   lock_state_r
);

   input wire clk;
   input wire reset;
   input wire [7:0] reg_addr;
   input wire reg_wr;
   input wire reg_rd;
   input wire [7:0] reg_wdata;
   output reg [7:0] reg_rdata_r;
   output reg reg_rvalid_r;
   input wire [7:0] current_sense_pin;
   input wire current_sense_valid;
   input wire [3:0] ramp_select_pin;
   input wire ramp_override_sel;
   input wire [4:0] limit_resistor_pin;
   input wire limit_override_sel;
   input wire [7:0] phase_limit_hit;
   output reg [3:0] active_ramp_code_r;
   output wire [13:0] ramp_time_us_r;
   output reg [4:0] active_limit_code_r;
   output wire [10:0] limit_threshold_mv_r;
   output reg overcurrent_warning_flag_r;
   output reg alert_r;
   output reg lock_state_r;

   // Lockable registers are the limit and configuration registers.
   function is_lockable;
      input [7:0] addr;
      begin
         is_lockable = (addr == `RLSR_ADDR_WARN_LIMIT) ||
                       (addr == `RLSR_ADDR_RAMP_CONFIG) ||
                       (addr == `RLSR_ADDR_PHASE_CONFIG);
      end
   endfunction

   reg [7:0] warn_limit_r;
   reg [7:0] readback_r;
   reg [3:0] ramp_status_r;
   reg [3:0] ramp_config_r;
   reg [4:0] phase_config_r;
   reg [7:0] phase_status_r;
   reg [7:0] phase_hit_d_r;
   reg strap_done_r;
   reg warn_status_r;
   reg [7:0] rdata_nxt;
   wire wr_ok;
   wire phase_status_rd;

   // A write to a lockable register is dropped silently once locked.
   assign wr_ok = reg_wr && !(lock_state_r && is_lockable(reg_addr));
   assign phase_status_rd = reg_rd && (reg_addr == `RLSR_ADDR_PHASE_STATUS);

   // The lock only sets; reset stands for the power cycle that clears it.
   always @(posedge clk) begin
      if (reset) begin
         lock_state_r <= 1'b0;
      end else if (reg_wr && reg_addr == `RLSR_ADDR_LOCK &&
                   reg_wdata[`RLSR_LOCK_BIT]) begin
         lock_state_r <= 1'b1;
      end
   end

   // Host-writable limit and configuration registers.
   always @(posedge clk) begin
      if (reset) begin
         warn_limit_r <= `RLSR_WARN_LIMIT_RST;
         ramp_config_r <= `RLSR_RAMP_CONFIG_RST;
         phase_config_r <= `RLSR_PHASE_CONFIG_RST;
      end else if (wr_ok) begin
         case (reg_addr)
            `RLSR_ADDR_WARN_LIMIT: begin
               warn_limit_r <= reg_wdata;
            end
            `RLSR_ADDR_RAMP_CONFIG: begin
               ramp_config_r <= reg_wdata[`RLSR_RAMP_MSB:0];
            end
            `RLSR_ADDR_PHASE_CONFIG: begin
               phase_config_r <= reg_wdata[`RLSR_LIMIT_MSB:0];
            end
            default: begin
               warn_limit_r <= warn_limit_r;
            end
         endcase
      end
   end

   // The strap is caught on the first clock after reset release, never by
   // the reset itself, so the pin level is read only when it has settled.
   always @(posedge clk) begin
      if (reset) begin
         strap_done_r <= 1'b0;
         ramp_status_r <= `RLSR_RAMP_STATUS_RST;
      end else if (!strap_done_r) begin
         strap_done_r <= 1'b1;
         ramp_status_r <= ramp_select_pin;
      end
   end

   // Each conversion result is held until the next one arrives.
   always @(posedge clk) begin
      if (reset) begin
         readback_r <= `RLSR_READBACK_RST;
      end else if (current_sense_valid) begin
         readback_r <= current_sense_pin;
      end
   end

   // Warning compare is strict: equal to the limit is not a warning, so the
   // all-ones reset value can never trip it.
   always @(posedge clk) begin
      if (reset) begin
         warn_status_r <= 1'b0;
         overcurrent_warning_flag_r <= 1'b0;
         alert_r <= 1'b0;
      end else begin
         warn_status_r <= readback_r > warn_limit_r;
         overcurrent_warning_flag_r <= readback_r > warn_limit_r;
         alert_r <= readback_r > warn_limit_r;
      end
   end

   // Select bits choose between host codes and strap or resistor codes.
   always @(posedge clk) begin
      if (reset) begin
         active_ramp_code_r <= `RLSR_RAMP_STATUS_RST;
         active_limit_code_r <= `RLSR_PHASE_CONFIG_RST;
      end else begin
         if (ramp_override_sel) begin
            active_ramp_code_r <= ramp_config_r;
         end else begin
            active_ramp_code_r <= ramp_status_r;
         end
         if (limit_override_sel) begin
            active_limit_code_r <= phase_config_r;
         end else begin
            active_limit_code_r <= limit_resistor_pin;
         end
      end
   end

   // Per-phase sticky status, set on entry to limit and cleared by a read.
   // A new entry in the reading cycle wins so no event is lost.
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi = gi + 1) begin : g_phase
         always @(posedge clk) begin
            if (reset) begin
               phase_hit_d_r[gi] <= 1'b0;
               phase_status_r[gi] <= 1'b0;
            end else begin
               phase_hit_d_r[gi] <= phase_limit_hit[gi];
               if (phase_limit_hit[gi] && !phase_hit_d_r[gi]) begin
                  phase_status_r[gi] <= 1'b1;
               end else if (phase_status_rd) begin
                  phase_status_r[gi] <= 1'b0;
               end
            end
         end
      end
   endgenerate

   // Read multiplexer; reserved bits and unmapped offsets read as zero.
   always @* begin
      case (reg_addr)
         `RLSR_ADDR_WARN_LIMIT: rdata_nxt = warn_limit_r;
         `RLSR_ADDR_WARN_STATUS: rdata_nxt = {7'h00, warn_status_r};
         `RLSR_ADDR_READBACK: rdata_nxt = readback_r;
         `RLSR_ADDR_LOCK: rdata_nxt = {7'h00, lock_state_r};
         `RLSR_ADDR_RAMP_STATUS: rdata_nxt = {4'h0, ramp_status_r};
         `RLSR_ADDR_RAMP_CONFIG: rdata_nxt = {4'h0, ramp_config_r};
         `RLSR_ADDR_PHASE_STATUS: rdata_nxt = phase_status_r;
         `RLSR_ADDR_PHASE_CONFIG: rdata_nxt = {3'h0, phase_config_r};
         default: rdata_nxt = 8'h00;
      endcase
   end

   // Read data appear one cycle after the read strobe.
   always @(posedge clk) begin
      if (reset) begin
         reg_rdata_r <= 8'h00;
         reg_rvalid_r <= 1'b0;
      end else begin
         reg_rvalid_r <= reg_rd;
         if (reg_rd) begin
            reg_rdata_r <= rdata_nxt;
         end
      end
   end

   // Unit conversion of the active codes for the regulation loop.
   rlsr_scale u_scale (
      .clk(clk),
      .reset(reset),
      .ramp_code(active_ramp_code_r),
      .limit_code(active_limit_code_r),
      .ramp_time_us_r(ramp_time_us_r),
      .limit_mv_r(limit_threshold_mv_r)
   );

endmodule

// File: rtl/rlsr_scale.v
`timescale 1ns/1ps
`include "rlsr_defs.vh"

// Converts the active ramp and limit codes to physical units.
module rlsr_scale (
   input wire clk,
   input wire reset,
   input wire [3:0] ramp_code,
   input wire [4:0] limit_code,
   output reg [13:0] ramp_time_us_r,
   output reg [10:0] limit_mv_r
);

   reg [13:0] ramp_nxt;
   reg [10:0] limit_nxt;

   // Short codes step by 150 us except code six, which is 1 ms; long codes step 1 ms.
   always @* begin
      if (ramp_code == `RLSR_RAMP_CODE6) begin
         ramp_nxt = `RLSR_RAMP_CODE6_US;
      end else if (ramp_code < `RLSR_RAMP_FIRST_SLOW) begin
         ramp_nxt = `RLSR_RAMP_FAST_STEP_US * {10'h000, ramp_code + 4'h1};
      end else begin
         ramp_nxt = `RLSR_RAMP_SLOW_STEP_US *
                    {10'h000, ramp_code - `RLSR_RAMP_SLOW_OFFSET};
      end
      limit_nxt = `RLSR_LIMIT_BASE_MV +
                  `RLSR_LIMIT_STEP_MV * {6'h00, limit_code};
   end

   // Registered so that downstream timing sees a clean value.
   always @(posedge clk) begin
      if (reset) begin
         ramp_time_us_r <= 14'h0000;
         limit_mv_r <= 11'h000;
      end else begin
         ramp_time_us_r <= ramp_nxt;
         limit_mv_r <= limit_nxt;
      end
   end

endmodule
